//--- src/uss_regs.svh
`ifndef USS_REGS_SVH
`define USS_REGS_SVH
// Register byte offsets
`define USS_OFF_CTRL      8'h00
`define USS_OFF_FLAG      8'h04
`define USS_OFF_FLAG_CLR  8'h08
`define USS_OFF_ENABLE    8'h0C
`define USS_OFF_STATUS    8'h10
`define USS_OFF_PERIPH    8'h14
`define USS_OFF_BDADDR    8'h18
`define USS_OFF_BUFWIN    8'h1C
// Control bits
`define USS_CTRL_SUSPEND  0
`define USS_CTRL_WAKEREQ  1
// Event flag bits
`define USS_FLG_TRN       0
`define USS_FLG_ACTV      1
// Descriptor memory
`define USS_BD_BASE       12'h400
`define USS_BD_BYTES      4
`define USS_BUF_END       12'h7FF
`define USS_ACCESS_END    12'h05F
// Resume timing and status queue depth
`define USS_RESUME_US     2000
`define USS_CLK_MHZ       100
`define USS_RESUME_CYC    (`USS_RESUME_US * `USS_CLK_MHZ)
`define USS_FIFO_DEPTH    4
`endif

//--- src/uss_pkg.sv
package uss_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SUSPEND,
    ST_RESUME
  } uss_state_t;
  typedef logic [7:0] uss_stat_t;
endpackage

//--- src/uss_stat_fifo.sv
`include "uss_regs.svh"
module uss_stat_fifo #(
  parameter int DEPTH = `USS_FIFO_DEPTH,
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Push side
  input wire logic push,
  input wire logic [W-1:0] din,
  // Pop side
  input wire logic pop,
  output logic [W-1:0] head,
  output logic empty,
  output logic full,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] cnt_r;
  logic [$clog2(DEPTH)-1:0] rd_r;
  logic [$clog2(DEPTH)-1:0] wr_r;
  logic do_push;
  logic do_pop;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("bad depth");
  end
  assign level = cnt_r;
  assign empty = (cnt_r == '0);
  assign full = (cnt_r == ($clog2(DEPTH)+1)'(DEPTH));
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rd_r];
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_r] <= din;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      rd_r <= '0;
      wr_r <= '0;
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // uss_stat_fifo

//--- src/uss_core.sv
// Behaviour
// - Descriptors sit at fixed bank-4 addresses
// - One four-byte descriptor per direction
// - Buffers in shared RAM after descriptors
// - Engine writes buffers independently of processor
// - Buffers never in fast-access RAM
// - Transaction end sets done flag, status
// - Four-deep status queue, clear pops one
// - Full queue blocks further transactions
// - Clearing flag discards head status
// - Event flags and enables readable
// - Suspend under software, activity sets flag
// - Wake needs activity and main enables
// - Remote wakeup drives resume upstream
`include "uss_regs.svh"
module uss_core #(
  parameter int RESUME_CYC = `USS_RESUME_CYC,
  parameter int EP_MAX = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Packet engine side
  input wire logic trn_done,
  input wire logic [7:0] trn_stat,
  output logic trn_hold,
  input wire logic bus_activity,
  // Buffer RAM engine port
  input wire logic eng_wr,
  input wire logic [11:0] eng_addr,
  input wire logic [7:0] eng_data,
  output logic eng_err,
  // Bus and wake
  output logic suspended,
  output logic resume_drive,
  output logic wake_req,
  output logic irq
);
  // ----------------------------------------------------------------
  // Shared buffer RAM
  // ----------------------------------------------------------------
  localparam int RAM_W = 1024;
  logic [7:0] ram [RAM_W];
  logic eng_ok;
  // Engine may only touch the shared window
  assign eng_ok = eng_addr >= `USS_BD_BASE && eng_addr <= `USS_BUF_END;
  always_ff @(posedge clk) begin
    if (eng_wr && eng_ok) begin
      ram[eng_addr[9:0]] <= eng_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eng_err <= 1'b0;
    end else begin
      eng_err <= eng_wr && !eng_ok;
    end
  end

  if (EP_MAX < 0 || EP_MAX > 15) begin : g_bad_ep
    $error("bad endpoint count");
  end
  if (RESUME_CYC < 1) begin : g_bad_resume
    $error("bad resume count");
  end

  // Fixed descriptor address of endpoint and direction
  function automatic logic [11:0] bd_addr(input logic [3:0] ep,
                                          input logic dir);
    bd_addr = `USS_BD_BASE + 12'({ep, dir}) * 12'(`USS_BD_BYTES);
  endfunction
  logic [11:0] buf_base;
  // First free buffer byte after all descriptors
  assign buf_base = bd_addr(4'(EP_MAX), 1'b1) + 12'(`USS_BD_BYTES);

  // ----------------------------------------------------------------
  // Status queue
  // ----------------------------------------------------------------
  logic q_pop;
  logic q_empty;
  logic q_full;
  logic [7:0] q_head;
  localparam int QW = $clog2(`USS_FIFO_DEPTH) + 1;
  logic [QW-1:0] q_level;
  logic q_near_full;
  assign q_near_full = q_level == QW'(`USS_FIFO_DEPTH - 1);
  uss_stat_fifo #(.DEPTH(`USS_FIFO_DEPTH), .W(8)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .push(trn_done),
    .din(trn_stat),
    .pop(q_pop),
    .head(q_head),
    .empty(q_empty),
    .full(q_full),
    .level(q_level)
  );
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trn_hold <= 1'b0;
    end else begin
      // Hold follows the queue level after this edge, with no lag
      trn_hold <= !q_pop && (q_full || (trn_done && q_near_full));
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_r;
  logic [31:0] wd_r;
  logic wr_go;
  logic [31:0] ctrl_r;
  logic [1:0] en_r;
  logic periph_en_r;
  logic [11:0] buf_ptr_r;
  logic [1:0] flag_r;
  logic clr_trn;
  logic clr_actv;
  uss_pkg::uss_state_t st_r;
  logic [$clog2(RESUME_CYC+1)-1:0] rcnt_r;

  assign wr_go = aw_got_r && w_got_r && !s_bvalid;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      s_awready <= !aw_got_r && !s_awready && s_awvalid;
      s_wready <= !w_got_r && !s_wready && s_wvalid;
      if (s_awvalid && s_awready) begin
        aw_got_r <= 1'b1;
        aw_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_wdata;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_bvalid <= 1'b1;
        case (aw_r)
          `USS_OFF_CTRL, `USS_OFF_FLAG_CLR, `USS_OFF_ENABLE,
          `USS_OFF_PERIPH, `USS_OFF_BUFWIN: s_bresp <= 2'h0;
          default: s_bresp <= 2'h2;
        endcase
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  assign clr_trn = wr_go && aw_r == `USS_OFF_FLAG_CLR &&
                   wd_r[`USS_FLG_TRN];
  assign clr_actv = wr_go && aw_r == `USS_OFF_FLAG_CLR &&
                    wd_r[`USS_FLG_ACTV];
  assign q_pop = clr_trn;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 32'h0000_0000;
      en_r <= 2'h0;
      periph_en_r <= 1'b0;
      buf_ptr_r <= 12'h000;
    end else begin
      if (ctrl_r[`USS_CTRL_WAKEREQ]) begin
        ctrl_r[`USS_CTRL_WAKEREQ] <= 1'b0;
      end
      if (wr_go && aw_r == `USS_OFF_CTRL) begin
        ctrl_r <= {30'h0, wd_r[1:0]};
      end
      if (wr_go && aw_r == `USS_OFF_ENABLE) begin
        en_r <= wd_r[1:0];
      end
      if (wr_go && aw_r == `USS_OFF_PERIPH) begin
        periph_en_r <= wd_r[0];
      end
      if (wr_go && aw_r == `USS_OFF_BUFWIN) begin
        buf_ptr_r <= wd_r[11:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= 2'h0;
        case (s_araddr)
          `USS_OFF_CTRL: s_rdata <= ctrl_r;
          `USS_OFF_FLAG: s_rdata <= {30'h0, flag_r};
          `USS_OFF_FLAG_CLR: s_rdata <= 32'h0000_0000;
          `USS_OFF_ENABLE: s_rdata <= {30'h0, en_r};
          `USS_OFF_STATUS: s_rdata <= {21'h0, q_full, q_empty,
                                      st_r == uss_pkg::ST_SUSPEND,
                                      q_head};
          `USS_OFF_PERIPH: s_rdata <= {31'h0, periph_en_r};
          `USS_OFF_BDADDR: s_rdata <= {20'h0, buf_base};
          `USS_OFF_BUFWIN: s_rdata <= {12'h0, buf_ptr_r,
                                      ram[buf_ptr_r[9:0]]};
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'h2;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic actv_evt;
  assign actv_evt = bus_activity && st_r == uss_pkg::ST_SUSPEND;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 2'h0;
    end else begin
      // Done flag mirrors queue occupancy after any pop
      flag_r[`USS_FLG_TRN] <= trn_done ||
                              (!q_empty && !(clr_trn &&
                              q_level == QW'(1)));
      if (actv_evt) begin
        flag_r[`USS_FLG_ACTV] <= 1'b1;
      end else if (clr_actv) begin
        flag_r[`USS_FLG_ACTV] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq <= periph_en_r && |(flag_r & en_r);
      wake_req <= periph_en_r && en_r[`USS_FLG_ACTV] &&
                  flag_r[`USS_FLG_ACTV];
    end
  end

  // ----------------------------------------------------------------
  // Suspend and resume
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= uss_pkg::ST_ACTIVE;
      rcnt_r <= '0;
    end else begin
      case (st_r)
        uss_pkg::ST_ACTIVE: begin
          if (ctrl_r[`USS_CTRL_SUSPEND]) begin
            st_r <= uss_pkg::ST_SUSPEND;
          end
        end
        uss_pkg::ST_SUSPEND: begin
          if (ctrl_r[`USS_CTRL_WAKEREQ]) begin
            st_r <= uss_pkg::ST_RESUME;
            rcnt_r <= '0;
          end else if (!ctrl_r[`USS_CTRL_SUSPEND]) begin
            st_r <= uss_pkg::ST_ACTIVE;
          end
        end
        uss_pkg::ST_RESUME: begin
          rcnt_r <= rcnt_r + 1'b1;
          if (rcnt_r == ($bits(rcnt_r))'(RESUME_CYC - 1)) begin
            st_r <= uss_pkg::ST_ACTIVE;
          end
        end
        default: st_r <= uss_pkg::ST_ACTIVE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resume_drive <= 1'b0;
      suspended <= 1'b0;
    end else begin
      resume_drive <= st_r == uss_pkg::ST_RESUME;
      suspended <= st_r == uss_pkg::ST_SUSPEND;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_full_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    q_full |-> trn_hold)
    else $error("hold missing while queue full");
  a_actv_sets: assert property (
    @(posedge clk) disable iff (!rst_b)
    actv_evt |=> flag_r[`USS_FLG_ACTV])
    else $error("activity flag not set");
  a_pop_one: assert property (
    @(posedge clk) disable iff (!rst_b)
    (q_pop && !trn_done && !q_empty) |=>
    q_level == $past(q_level) - QW'(1))
    else $error("clear did not pop one");
  a_done_flag: assert property (
    @(posedge clk) disable iff (!rst_b)
    trn_done |=> flag_r[`USS_FLG_TRN])
    else $error("done flag not set");
  a_wake_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    wake_req |-> $past(periph_en_r) && $past(en_r[`USS_FLG_ACTV]))
    else $error("wake without enables");
  a_resume_len: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(st_r == uss_pkg::ST_RESUME) |=>
    st_r == uss_pkg::ST_RESUME [*8])
    else $error("resume too short");
  a_irq_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    irq |-> $past(periph_en_r) && |($past(flag_r) & $past(en_r)))
    else $error("irq without enabled flag");
  a_eng_window: assert property (
    @(posedge clk) disable iff (!rst_b)
    (eng_wr && eng_addr <= `USS_ACCESS_END) |=> eng_err)
    else $error("fast ram write not flagged");
  c_fill: cover property (@(posedge clk) disable iff (!rst_b) q_full);
  c_suspend: cover property (@(posedge clk) disable iff (!rst_b) actv_evt);
  c_resume: cover property (@(posedge clk) disable iff (!rst_b)
    resume_drive);
endmodule // uss_core

//--- verification/uss_host_model.sv
module uss_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench commands
  input wire logic snd,
  input wire logic [7:0] snd_stat,
  input wire logic act,
  output logic pend,
  // Engine side
  input wire logic trn_hold,
  output logic trn_done,
  output logic [7:0] trn_stat,
  output logic bus_activity
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] stat_r;
  // Status lines toggle when idle so a stale value never looks valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 1'h0;
      trn_done <= 1'h0;
      trn_stat <= 8'h00;
      stat_r <= 8'h00;
      bus_activity <= 1'h0;
    end else begin
      bus_activity <= act;
      trn_done <= 1'h0;
      trn_stat <= ~trn_stat;
      if (snd) begin
        pend <= 1'h1;
        stat_r <= snd_stat;
      end else if (pend && !trn_hold) begin
        pend <= 1'h0;
        trn_done <= 1'h1;
        trn_stat <= stat_r;
      end
    end
  end
endmodule // uss_host_model

//--- verification/tb.sv
`include "uss_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, eng_data = 8'h00;
  logic [7:0] snd_stat = 8'h00, trn_stat;
  logic [31:0] s_wdata = 32'h0, s_rdata, d;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0, eng_wr = 1'h0;
  logic snd = 1'h0, act = 1'h0, pend;
  logic [11:0] eng_addr = 12'h000;
  logic [1:0] s_bresp, s_rresp, r;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic trn_done, trn_hold, bus_activity, eng_err;
  logic suspended, resume_drive, wake_req, irq;
  int failures = 0;
  int compares = 0;
  int rcnt = 0;
  int r0;
  logic [11:0] ea [4] = '{12'h05F, 12'h7FF, 12'h3FF, 12'h400};

  always #5 clk = ~clk;
  always @(posedge clk) if (resume_drive === 1'h1) rcnt <= rcnt + 1;

  // Five endpoints reserved as in a design using endpoints 0 and 4
  uss_core #(.RESUME_CYC(16), .EP_MAX(4)) u_uss_core (
    .clk, .rst_b, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .trn_done, .trn_stat, .trn_hold, .bus_activity, .eng_wr, .eng_addr,
    .eng_data, .eng_err, .suspended, .resume_drive, .wake_req, .irq);
  uss_host_model u_uss_host_model (.clk, .rst_b, .snd, .snd_stat, .act,
    .pend, .trn_hold, .trn_done, .trn_stat, .bus_activity);

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string m);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s saw %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      failures++;
      close_out();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    s_awaddr <= a;
    s_awvalid <= 1'h1;
    s_wdata <= v;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      tick(n);
      if (s_awvalid && s_awready) s_awvalid <= 1'h0;
      if (s_wvalid && s_wready) s_wvalid <= 1'h0;
    end while (s_bvalid !== 1'h1);
    rs = s_bresp;
    s_bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      tick(n);
      if (s_arvalid && s_arready) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axw(a, v, r);
    chk(32'(r), 32'h0, "write response");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [7:0] s, input bit w);
    int n;
    n = 0;
    @(posedge clk);
    snd <= 1'h1;
    snd_stat <= s;
    @(posedge clk);
    snd <= 1'h0;
    @(posedge clk);
    while (w && pend) tick(n);
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    wr(`USS_OFF_PERIPH, 32'h1);
    axr(`USS_OFF_FLAG, d, r);
    chk(d, 32'h0, "flags after reset");
    axr(`USS_OFF_BDADDR, d, r);
    chk(d, 32'h428, "first buffer");
    axr(8'h40, d, r);
    chk(32'(r), 32'h2, "unmapped read");
    axw(8'h44, 32'h1, r);
    chk(32'(r), 32'h2, "unmapped write");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      eng_wr <= 1'h1;
      eng_addr <= ea[i];
      eng_data <= 8'h5A + 8'(i);
      @(posedge clk);
      eng_wr <= 1'h0;
      #1;
      chk(32'(eng_err), 32'(i % 2 == 0),
          "engine range");
    end
    // Refused byte at 0x3FF must not alias the one at 0x7FF
    wr(`USS_OFF_BUFWIN, 32'h7FF);
    axr(`USS_OFF_BUFWIN, d, r);
    chk(d, 32'h7FF5B, "engine byte at end");
    wr(`USS_OFF_BUFWIN, 32'h400);
    axr(`USS_OFF_BUFWIN, d, r);
    chk(d, 32'h4005D, "engine byte at base");
    // Queue fills, holds the host off, pops one per clear
    for (int i = 0; i < 4; i++) send(8'hA1 + 8'(i), 1'h1);
    axr(`USS_OFF_STATUS, d, r);
    chk(d, 32'h4A1, "full queue");
    chk(32'(trn_hold), 32'h1, "hold");
    wr(`USS_OFF_ENABLE, 32'h1);
    settle();
    chk(32'(irq), 32'h1, "irq on");
    wr(`USS_OFF_ENABLE, 32'h0);
    settle();
    chk(32'(irq), 32'h0, "irq masked");
    send(8'hA5, 1'h0);
    repeat (10) @(posedge clk);
    chk(32'(pend), 32'h1, "fifth held");
    wr(`USS_OFF_FLAG_CLR, 32'h1);
    settle();
    chk(32'(pend), 32'h0, "fifth taken");
    for (int i = 0; i < 4; i++) begin
      axr(`USS_OFF_STATUS, d, r);
      chk(d, {21'h0, i == 0, 2'h0, 8'hA2 + 8'(i)}, "queue head");
      wr(`USS_OFF_FLAG_CLR, 32'h1);
    end
    axr(`USS_OFF_STATUS, d, r);
    chk(d & 32'h700, 32'h200, "queue empty");
    axr(`USS_OFF_FLAG, d, r);
    chk(d, 32'h0, "done flag off");
    // Suspend, bus activity and wake
    // Cable detached: software drops the main enable
    wr(`USS_OFF_PERIPH, 32'h0);
    wr(`USS_OFF_ENABLE, 32'h2);
    wr(`USS_OFF_CTRL, 32'h1);
    settle();
    chk(32'(suspended), 32'h1, "suspended");
    axr(`USS_OFF_STATUS, d, r);
    chk(d & 32'h100, 32'h100, "status suspended");
    axr(`USS_OFF_ENABLE, d, r);
    chk(d, 32'h2, "enable readback");
    @(posedge clk);
    act <= 1'h1;
    @(posedge clk);
    act <= 1'h0;
    settle();
    axr(`USS_OFF_FLAG, d, r);
    chk(d, 32'h2, "activity flag");
    chk(32'(wake_req), 32'h0, "wake without main");
    wr(`USS_OFF_PERIPH, 32'h1);
    settle();
    chk(32'(wake_req), 32'h1, "wake");
    chk(32'(irq), 32'h1, "wake irq");
    wr(`USS_OFF_ENABLE, 32'h0);
    wr(`USS_OFF_CTRL, 32'h0);
    wr(`USS_OFF_FLAG_CLR, 32'h2);
    settle();
    chk(32'(wake_req), 32'h0, "wake off");
    chk(32'(suspended), 32'h0, "left suspend");
    // Remote wakeup resume length
    wr(`USS_OFF_CTRL, 32'h1);
    r0 = rcnt;
    wr(`USS_OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    #1;
    chk(32'(rcnt - r0), 32'h10, "resume length");
    chk(32'(resume_drive), 32'h0, "resume released");
    wr(`USS_OFF_CTRL, 32'h0);
    close_out();
  end
endmodule // tb
